// >>> hw/aumc_pkg.sv
package aumc_pkg;
    // clock and link timing
    localparam int CLK_HZ          = 100_000_000;
    localparam int BAUD            = 9600;
    localparam int BIT_CYCLES      = CLK_HZ / BAUD;
    localparam int REPORT_MS       = 500;
    localparam int REPORT_CYCLES   = (CLK_HZ / 1000) * REPORT_MS;
    // compensation: unity is 8192, product is shifted back by 13
    localparam logic [15:0] COMP_UNITY = 16'h2000;
    localparam int          COMP_SHIFT = 13;
    localparam logic [16:0] PPM_MAX    = 17'h1869F;
    localparam logic [15:0] PPM_RESET  = 16'h0000;
    localparam int          NUM_DIGITS = 5;
    // reply lengths in bytes
    localparam logic [3:0]  MSG_LEN_LONG  = 4'hA;
    localparam logic [3:0]  MSG_LEN_SHORT = 4'h4;
    // ascii codes
    localparam logic [7:0]  CH_SP    = 8'h20;
    localparam logic [7:0]  CH_CR    = 8'h0D;
    localparam logic [7:0]  CH_LF    = 8'h0A;
    localparam logic [7:0]  CH_QUERY = 8'h3F;
    localparam logic [7:0]  CH_MODE  = 8'h4B;
    localparam logic [7:0]  CH_COMP  = 8'h53;
    localparam logic [7:0]  CH_CONC  = 8'h5A;
    localparam logic [7:0]  CH_ZERO  = 8'h30;
    localparam logic [7:0]  CH_NINE  = 8'h39;

    typedef enum logic [1:0] {
        MODE_CMD    = 2'b00,
        MODE_STREAM = 2'b01,
        MODE_POLL   = 2'b10
    } aumc_mode_e;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } aumc_byte_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] ppm;
    } aumc_meas_s;
endpackage

// >>> hw/aumc_uart_rx.sv
`timescale 1ns/1ps
module aumc_uart_rx #(
    parameter int BIT_CYCLES = aumc_pkg::BIT_CYCLES
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             rx_line,
    output aumc_pkg::aumc_byte_s  rx_byte
);
    localparam int CW = $clog2(BIT_CYCLES + 1);

    generate
        if (BIT_CYCLES < 4) begin : g_chk
            $error("aumc_uart_rx: BIT_CYCLES too small");
        end
    endgenerate

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } aumc_rx_e;

    aumc_rx_e     state;
    logic [CW-1:0] cnt;
    logic [2:0]    nbit;
    logic [7:0]    shift;

    ////////////////////////////////////////////////////////////////////////////
    // start, 8 data lsb first, 1 stop, sampled mid-bit
    always_ff @(posedge mclk) begin
        if (reset) begin
            state         <= RX_IDLE;
            cnt           <= '0;
            nbit          <= 3'h0;
            shift         <= 8'h00;
            rx_byte.valid <= 1'b0;
            rx_byte.data  <= 8'h00;
        end else begin
            rx_byte.valid <= 1'b0;
            if (cnt != '0) begin
                cnt <= cnt - 1'b1;
            end
            case (state)
                RX_IDLE: begin
                    if (!rx_line) begin
                        state <= RX_START;
                        cnt   <= CW'(BIT_CYCLES / 2);
                    end
                end
                RX_START: begin
                    if (cnt == '0) begin
                        state <= rx_line ? RX_IDLE : RX_DATA;
                        cnt   <= CW'(BIT_CYCLES - 1);
                        nbit  <= 3'h0;
                    end
                end
                RX_DATA: begin
                    if (cnt == '0) begin
                        shift <= {rx_line, shift[7:1]};
                        cnt   <= CW'(BIT_CYCLES - 1);
                        nbit  <= nbit + 3'h1;
                        if (nbit == 3'h7) begin
                            state <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (cnt == '0) begin
                        state         <= RX_IDLE;
                        rx_byte.valid <= rx_line;
                        rx_byte.data  <= shift;
                    end
                end
                default: state <= RX_IDLE;
            endcase
        end
    end
endmodule

// >>> hw/aumc_ctrl.sv
// Summary of operation
// - reading scaled by compensation value over 8192; 8192 means no correction
// - compensation setting applies to every later reading until changed
// - serial input and output lines idle high
// - malformed command, or unrecognised character in mode 0, answered with a question mark
// - every reply begins with a space and ends with CR LF
// - numeric fields are ascii decimal digits 0 to 9
// - after power-up the first measurement starts at once, with no received character needed
// - any character other than K, S, CR, LF received at the start of a line yields one reading in modes 1 and 2
// - report is Z, space, five digits of ppm, CR LF
// - measurements taken twice per second at 9600 baud
// - requests faster than measurements repeat the last completed result
// - at power-up measuring starts on its own in the stored mode, streaming 1 or polling 2
// - mode 0 sleeps, takes no measurements, answers commands at once
// - mode 0 refuses commands that report measurements
// - mode 0 is never restored after power returns
// - streaming reports twice per second; command replies wait at most 100ms
// - polling mode measures in background, reports only on request
// - stored streaming or polling choice is restored at power-up
// - K, space, mode digit, terminator selects mode and is echoed
`timescale 1ns/1ps
module aumc_ctrl #(
    parameter int BIT_CYCLES    = aumc_pkg::BIT_CYCLES,
    parameter int REPORT_CYCLES = aumc_pkg::REPORT_CYCLES
) (
    input  wire logic                mclk,
    input  wire logic                reset,
    input  wire logic                rx_in,
    input  wire aumc_pkg::aumc_meas_s meas_in,
    input  wire logic                nv_poll_in,
    output logic                     tx_out,
    output logic                     meas_start,
    output aumc_pkg::aumc_mode_e     mode,
    output logic                     nv_wr,
    output logic                     nv_poll
);
    localparam int BW = $clog2(BIT_CYCLES + 1);
    localparam int RW = $clog2(REPORT_CYCLES + 1);

    generate
        if (BIT_CYCLES < 4 || REPORT_CYCLES < 2) begin : g_chk
            $error("aumc_ctrl: timing parameters out of range");
        end
    endgenerate

    typedef enum logic [2:0] {
        P_IDLE = 3'b000,
        P_SP   = 3'b001,
        P_ARG  = 3'b010,
        P_LF   = 3'b011,
        P_SKIP = 3'b100
    } aumc_parse_e;

    typedef enum logic [1:0] {
        T_IDLE = 2'b00,
        T_CONV = 2'b01,
        T_LOAD = 2'b10,
        T_BITS = 2'b11
    } aumc_tx_e;

    logic                 rx_meta;
    logic                 rx_sync;
    aumc_pkg::aumc_byte_s rxb;
    aumc_parse_e          pstate;
    logic [7:0]           cmd;
    logic [16:0]          arg;
    logic [2:0]           ndig;
    logic                 bad;
    logic                 booted;
    logic                 is_digit;
    logic                 exec_k;
    logic                 exec_s;
    logic                 want_q;
    logic                 want_z;
    logic                 req_q;
    logic                 req_k;
    logic                 req_s;
    logic                 req_z;
    logic [15:0]          comp;
    logic [16:0]          latest;
    logic [31:0]          prod;
    logic [18:0]          scaled;
    logic [RW-1:0]        rpt_cnt;
    aumc_tx_e             tstate;
    logic [7:0]           letter;
    logic                 short_msg;
    logic [16:0]          conv;
    logic [2:0]           ci;
    logic [3:0]           dig [aumc_pkg::NUM_DIGITS];
    logic [3:0]           idx;
    logic [7:0]           cur_byte;
    logic [9:0]           frame;
    logic [3:0]           nbits;
    logic [BW-1:0]        bcnt;

    function automatic logic [16:0] pow10(input logic [2:0] i);
        case (i)
            3'h0:    pow10 = 17'h02710;
            3'h1:    pow10 = 17'h003E8;
            3'h2:    pow10 = 17'h00064;
            3'h3:    pow10 = 17'h0000A;
            default: pow10 = 17'h00001;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser and receiver
    always_ff @(posedge mclk) begin
        if (reset) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= rx_in;
            rx_sync <= rx_meta;
        end
    end

    aumc_uart_rx #(
        .BIT_CYCLES (BIT_CYCLES)
    ) u_rx (
        .mclk    (mclk),
        .reset   (reset),
        .rx_line (rx_sync),
        .rx_byte (rxb)
    );

    ////////////////////////////////////////////////////////////////////////////
    // command parser
    assign is_digit = (rxb.data >= aumc_pkg::CH_ZERO) && (rxb.data <= aumc_pkg::CH_NINE);

    always_comb begin
        exec_k = 1'b0;
        exec_s = 1'b0;
        want_q = 1'b0;
        want_z = 1'b0;
        if (rxb.valid) begin
            case (pstate)
                P_IDLE: begin
                    if (rxb.data != aumc_pkg::CH_MODE && rxb.data != aumc_pkg::CH_COMP &&
                        rxb.data != aumc_pkg::CH_CR && rxb.data != aumc_pkg::CH_LF) begin
                        want_z = (mode != aumc_pkg::MODE_CMD);
                        want_q = (mode == aumc_pkg::MODE_CMD);
                    end
                end
                P_SP: want_q = (rxb.data == aumc_pkg::CH_LF);
                P_ARG: want_q = (rxb.data == aumc_pkg::CH_LF);
                P_LF: begin
                    if (rxb.data == aumc_pkg::CH_LF) begin
                        exec_k = (cmd == aumc_pkg::CH_MODE) && (arg <= 17'h00002);
                        exec_s = (cmd == aumc_pkg::CH_COMP) && (arg <= 17'h0FFFF);
                        want_q = !exec_k && !exec_s;
                    end
                end
                P_SKIP: want_q = (rxb.data == aumc_pkg::CH_LF) && bad;
                default: want_q = 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            pstate <= P_IDLE;
            cmd    <= 8'h00;
            arg    <= 17'h00000;
            ndig   <= 3'h0;
            bad    <= 1'b0;
        end else if (rxb.valid) begin
            case (pstate)
                P_IDLE: begin
                    if (rxb.data == aumc_pkg::CH_MODE || rxb.data == aumc_pkg::CH_COMP) begin
                        cmd    <= rxb.data;
                        pstate <= P_SP;
                    end else if (rxb.data != aumc_pkg::CH_CR && rxb.data != aumc_pkg::CH_LF) begin
                        bad    <= 1'b0;
                        pstate <= P_SKIP;
                    end
                end
                P_SP: begin
                    arg  <= 17'h00000;
                    ndig <= 3'h0;
                    bad  <= 1'b1;
                    if (rxb.data == aumc_pkg::CH_SP) begin
                        pstate <= P_ARG;
                    end else begin
                        pstate <= (rxb.data == aumc_pkg::CH_LF) ? P_IDLE : P_SKIP;
                    end
                end
                P_ARG: begin
                    if (is_digit && ndig < 3'(aumc_pkg::NUM_DIGITS)) begin
                        arg  <= 17'(arg * 17'h0000A + {9'h000, rxb.data - aumc_pkg::CH_ZERO});
                        ndig <= ndig + 3'h1;
                    end else if (rxb.data == aumc_pkg::CH_CR && ndig != 3'h0) begin
                        pstate <= P_LF;
                    end else begin
                        pstate <= (rxb.data == aumc_pkg::CH_LF) ? P_IDLE : P_SKIP;
                    end
                end
                P_LF: pstate <= (rxb.data == aumc_pkg::CH_LF) ? P_IDLE : P_SKIP;
                P_SKIP: begin
                    if (rxb.data == aumc_pkg::CH_LF) begin
                        pstate <= P_IDLE;
                    end
                end
                default: pstate <= P_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode, non-volatile mode store, compensation setting
    always_ff @(posedge mclk) begin
        if (reset) begin
            mode   <= aumc_pkg::MODE_STREAM;
            booted <= 1'b0;
        end else if (!booted) begin
            booted <= 1'b1;
            mode   <= nv_poll_in ? aumc_pkg::MODE_POLL : aumc_pkg::MODE_STREAM;
        end else if (exec_k) begin
            mode <= aumc_pkg::aumc_mode_e'(arg[1:0]);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            nv_wr   <= 1'b0;
            nv_poll <= 1'b0;
        end else begin
            nv_wr <= exec_k && (arg[1:0] != aumc_pkg::MODE_CMD);
            if (exec_k && (arg[1:0] != aumc_pkg::MODE_CMD)) begin
                nv_poll <= (arg[1:0] == aumc_pkg::MODE_POLL);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            comp <= aumc_pkg::COMP_UNITY;
        end else if (exec_s) begin
            comp <= arg[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // measurement pacing and compensated result
    always_ff @(posedge mclk) begin
        if (reset) begin
            rpt_cnt    <= '0;
            meas_start <= 1'b0;
        end else begin
            meas_start <= 1'b0;
            if (mode == aumc_pkg::MODE_CMD) begin
                rpt_cnt <= '0;
            end else if (rpt_cnt == '0) begin
                rpt_cnt    <= RW'(REPORT_CYCLES - 1);
                meas_start <= 1'b1;
            end else begin
                rpt_cnt <= rpt_cnt - 1'b1;
            end
        end
    end

    assign prod   = meas_in.ppm * comp;
    assign scaled = prod[aumc_pkg::COMP_SHIFT +: 19];

    always_ff @(posedge mclk) begin
        if (reset) begin
            latest <= {1'b0, aumc_pkg::PPM_RESET};
        end else if (meas_in.valid && mode != aumc_pkg::MODE_CMD) begin
            latest <= (scaled > {2'b00, aumc_pkg::PPM_MAX}) ? aumc_pkg::PPM_MAX
                                                            : scaled[16:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pending replies: a new request wins over the clear
    always_ff @(posedge mclk) begin
        if (reset) begin
            req_q <= 1'b0;
            req_k <= 1'b0;
            req_s <= 1'b0;
            req_z <= 1'b0;
        end else begin
            if (tstate == T_IDLE) begin
                if (req_q) begin
                    req_q <= 1'b0;
                end else if (req_k) begin
                    req_k <= 1'b0;
                end else if (req_s) begin
                    req_s <= 1'b0;
                end else if (req_z) begin
                    req_z <= 1'b0;
                end
            end
            if (want_q) begin
                req_q <= 1'b1;
            end
            if (exec_k) begin
                req_k <= 1'b1;
            end
            if (exec_s) begin
                req_s <= 1'b1;
            end
            if (want_z || (meas_in.valid && mode == aumc_pkg::MODE_STREAM)) begin
                req_z <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reply builder: space, letter, space, five digits, CR LF; short reply is space, letter, CR LF
    always_comb begin
        cur_byte = aumc_pkg::CH_SP;
        if (short_msg) begin
            case (idx)
                4'h1:    cur_byte = letter;
                4'h2:    cur_byte = aumc_pkg::CH_CR;
                4'h3:    cur_byte = aumc_pkg::CH_LF;
                default: cur_byte = aumc_pkg::CH_SP;
            endcase
        end else begin
            case (idx)
                4'h1:    cur_byte = letter;
                4'h3:    cur_byte = aumc_pkg::CH_ZERO | {4'h0, dig[0]};
                4'h4:    cur_byte = aumc_pkg::CH_ZERO | {4'h0, dig[1]};
                4'h5:    cur_byte = aumc_pkg::CH_ZERO | {4'h0, dig[2]};
                4'h6:    cur_byte = aumc_pkg::CH_ZERO | {4'h0, dig[3]};
                4'h7:    cur_byte = aumc_pkg::CH_ZERO | {4'h0, dig[4]};
                4'h8:    cur_byte = aumc_pkg::CH_CR;
                4'h9:    cur_byte = aumc_pkg::CH_LF;
                default: cur_byte = aumc_pkg::CH_SP;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            tstate    <= T_IDLE;
            letter    <= aumc_pkg::CH_SP;
            short_msg <= 1'b0;
            conv      <= 17'h00000;
            ci        <= 3'h0;
            idx       <= 4'h0;
            frame     <= 10'h3FF;
            nbits     <= 4'h0;
            bcnt      <= '0;
            tx_out    <= 1'b1;
            for (int i = 0; i < aumc_pkg::NUM_DIGITS; i++) begin
                dig[i] <= 4'h0;
            end
        end else begin
            if (bcnt != '0) begin
                bcnt <= bcnt - 1'b1;
            end
            case (tstate)
                T_IDLE: begin
                    idx <= 4'h0;
                    ci  <= 3'h0;
                    for (int i = 0; i < aumc_pkg::NUM_DIGITS; i++) begin
                        dig[i] <= 4'h0;
                    end
                    if (req_q || req_k || req_s || req_z) begin
                        tstate    <= T_CONV;
                        short_msg <= req_q;
                        if (req_q) begin
                            letter <= aumc_pkg::CH_QUERY;
                        end else if (req_k) begin
                            letter <= aumc_pkg::CH_MODE;
                            conv   <= {15'h0000, mode};
                        end else if (req_s) begin
                            letter <= aumc_pkg::CH_COMP;
                            conv   <= {1'b0, comp};
                        end else begin
                            letter <= aumc_pkg::CH_CONC;
                            conv   <= latest;
                        end
                    end
                end
                T_CONV: begin
                    if (conv >= pow10(ci)) begin
                        conv    <= conv - pow10(ci);
                        dig[ci] <= dig[ci] + 4'h1;
                    end else if (ci == 3'(aumc_pkg::NUM_DIGITS - 1)) begin
                        tstate <= T_LOAD;
                    end else begin
                        ci <= ci + 3'h1;
                    end
                end
                T_LOAD: begin
                    frame  <= {1'b1, cur_byte, 1'b0};
                    nbits  <= 4'hA;
                    bcnt   <= BW'(BIT_CYCLES - 1);
                    tx_out <= 1'b0;
                    tstate <= T_BITS;
                end
                T_BITS: begin
                    if (bcnt == '0) begin
                        if (nbits == 4'h1) begin
                            tx_out <= 1'b1;
                            idx    <= idx + 4'h1;
                            if (idx == (short_msg ? aumc_pkg::MSG_LEN_SHORT
                                                  : aumc_pkg::MSG_LEN_LONG) - 4'h1) begin
                                tstate <= T_IDLE;
                            end else begin
                                tstate <= T_LOAD;
                            end
                        end else begin
                            frame  <= {1'b1, frame[9:1]};
                            tx_out <= frame[1];
                            nbits  <= nbits - 4'h1;
                            bcnt   <= BW'(BIT_CYCLES - 1);
                        end
                    end
                end
                default: tstate <= T_IDLE;
            endcase
        end
    end
endmodule

// >>> testbench/aumc_ctrl_assertions.sv
`timescale 1ns/1ps
module aumc_ctrl_assertions #(
    parameter int BIT_CYCLES    = 16,
    parameter int REPORT_CYCLES = 2000
) (
    input logic                 mclk,
    input logic                 reset,
    input logic                 nv_poll_in,
    input logic                 tx_out,
    input logic                 meas_start,
    input aumc_pkg::aumc_mode_e mode,
    input logic                 nv_wr,
    input logic                 nv_poll
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    logic [31:0] gap;
    logic        run;
    ////////////////////////////////////////////////////////////////
    // cycles since the last start; run is clear after sleep or reset
    always_ff @(posedge mclk) gap <= meas_start ? 32'h0 : gap + 32'h1;
    always_ff @(posedge mclk) begin
        run <= (reset || mode == aumc_pkg::MODE_CMD) ? 1'b0 : (run | meas_start);
    end
    ////////////////////////////////////////////////////////////////
    AST_IDLE_AT_RELEASE: assert property (
        $fell(reset) |-> tx_out && mode == aumc_pkg::MODE_STREAM)
        else $error("bad output state at reset release");
    AST_MODE_RESTORE: assert property (
        $fell(reset) |=> mode == ($past(nv_poll_in) ? aumc_pkg::MODE_POLL
                                                    : aumc_pkg::MODE_STREAM))
        else $error("stored mode not restored");
    AST_FIRST_MEAS: assert property ($fell(reset) |=> meas_start)
        else $error("no measurement started after reset");
    AST_SLEEP_NO_MEAS: assert property (
        mode == aumc_pkg::MODE_CMD && $past(mode) == aumc_pkg::MODE_CMD |-> !meas_start)
        else $error("measurement started while asleep");
    AST_MEAS_PERIOD: assert property (meas_start && run |-> gap == REPORT_CYCLES - 1)
        else $error("measurement period wrong");
    AST_NV_PULSE: assert property (nv_wr |=> !nv_wr)
        else $error("store write longer than one cycle");
    AST_NV_MATCH: assert property (
        nv_wr |-> ##[0:2] mode == (nv_poll ? aumc_pkg::MODE_POLL : aumc_pkg::MODE_STREAM))
        else $error("stored mode differs from mode");
    AST_START_BIT: assert property ($fell(tx_out) |-> !tx_out [*8])
        else $error("start bit too short");
    cover property (nv_wr && nv_poll);
    cover property (mode == aumc_pkg::MODE_CMD);
    cover property ($fell(tx_out));
endmodule

// >>> testbench/aumc_host_model.sv
`timescale 1ns/1ps
module aumc_host_model #(
    parameter int BIT_CYCLES = 16
) (
    input  logic mclk,
    output logic rx_line,
    input  logic tx_line
);
    logic [7:0] rxq[$];
    logic [7:0] d;
    initial rx_line = 1'b1;
    ////////////////////////////////////////////////////////////////
    // one frame: start, eight data lsb first, stop
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_line = f[i];
            repeat (BIT_CYCLES) @(negedge mclk);
        end
    endtask
    task automatic send_cmd(input string s);
        for (int i = 0; i < s.len(); i++) send_byte(s[i]);
        send_byte(8'h0D);
        send_byte(8'h0A);
    endtask
    ////////////////////////////////////////////////////////////////
    // receiver; a bad stop bit is logged as 8'h7E
    initial forever begin
        @(negedge tx_line);
        repeat (BIT_CYCLES / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge mclk);
            d[i] = tx_line;
        end
        repeat (BIT_CYCLES) @(posedge mclk);
        rxq.push_back(tx_line === 1'b1 ? d : 8'h7E);
    end
endmodule

// >>> testbench/tb_aumc_ctrl.sv
`timescale 1ns/1ps
module tb_aumc_ctrl;
    localparam int REP = 2000;
    logic                 mclk       = 1'b0;
    logic                 reset      = 1'b1;
    logic                 rx_in;
    aumc_pkg::aumc_meas_s meas_in    = '0;
    logic                 nv_poll_in = 1'b0;
    logic                 tx_out;
    logic                 meas_start;
    aumc_pkg::aumc_mode_e mode;
    logic                 nv_wr;
    logic                 nv_poll;
    logic [15:0]          ppm        = 16'h0190;
    int                   err_total  = 0;
    int                   cmp_count  = 0;
    aumc_ctrl #(.BIT_CYCLES(16), .REPORT_CYCLES(REP)) aumc_ctrl_i (
        .mclk(mclk), .reset(reset), .rx_in(rx_in), .meas_in(meas_in),
        .nv_poll_in(nv_poll_in), .tx_out(tx_out), .meas_start(meas_start),
        .mode(mode), .nv_wr(nv_wr), .nv_poll(nv_poll));
    aumc_host_model #(.BIT_CYCLES(16)) aumc_host_model_i (
        .mclk(mclk), .rx_line(rx_in), .tx_line(tx_out));
    initial forever #5 mclk = ~mclk;
    // measurement core answers each start half a cycle later, on the falling edge
    always @(negedge mclk) begin
        meas_in.valid = meas_start;
        meas_in.ppm = ppm;
    end
    ////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one reply line, CR shown as R and LF as N
    task automatic get_line(output string s);
        logic [7:0] b;
        int         n;
        s = "";
        n = 0;
        b = 8'h00;
        while (b != 8'h0A) begin
            while (aumc_host_model_i.rxq.size() == 0) begin
                @(posedge mclk);
                n++;
                if (n > 20000) begin
                    err_total++;
                    finish_test();
                end
            end
            b = aumc_host_model_i.rxq.pop_front();
            if (b == 8'h0D) s = {s, "R"};
            else if (b == 8'h0A) s = {s, "N"};
            else s = {s, string'(b)};
        end
    endtask
    // stream reports are skipped while another reply is awaited
    task automatic expect_line(input string what, input string exp);
        string s;
        get_line(s);
        while (s.len() > 1 && s[1] == 8'h5A && exp[1] != 8'h5A) get_line(s);
        cmp_count++;
        if (s != exp) begin
            err_total++;
            $display("mismatch %s expected %s seen %s", what, exp, s);
        end
    endtask
    task automatic cmd(input string s);
        @(negedge mclk);
        aumc_host_model_i.send_cmd(s);
    endtask
    task automatic quiet(input string what);
        aumc_host_model_i.rxq.delete();
        repeat (2 * REP) @(negedge mclk);
        check_val(what, 16'h0000, 16'(aumc_host_model_i.rxq.size()));
    endtask
    task automatic do_reset(input logic nv);
        nv_poll_in = nv;
        reset = 1'b1;
        repeat (8) @(negedge mclk);
        reset = 1'b0;
        repeat (2) @(negedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_stream();
        do_reset(1'b0);
        check_val("mode", 16'(aumc_pkg::MODE_STREAM), 16'(mode));
        expect_line("report", " Z 00400RN");
        expect_line("next report", " Z 00400RN");
    endtask
    task automatic t_poll();
        cmd("K 2");
        expect_line("mode echo", " K 00002RN");
        check_val("nv", 16'h0001, 16'(nv_poll));
        repeat (1700) @(negedge mclk);
        quiet("poll quiet");
    endtask
    task automatic t_comp();
        cmd("S 8398");
        expect_line("comp echo", " S 08398RN");
        ppm = 16'h03E8;
        @(posedge meas_start);
        repeat (4) @(negedge mclk);
        ppm = 16'h07D0;
        cmd("Q");
        expect_line("last", $sformatf(" Z %05dRN", (1000 * 8398) >> 13));
        @(posedge meas_start);
        repeat (4) @(negedge mclk);
        cmd("Q");
        expect_line("again", $sformatf(" Z %05dRN", (2000 * 8398) >> 13));
    endtask
    task automatic t_sleep();
        cmd("K 0");
        expect_line("sleep echo", " K 00000RN");
        check_val("mode", 16'(aumc_pkg::MODE_CMD), 16'(mode));
        cmd("Q");
        expect_line("refused", " ?RN");
        cmd("K2");
        expect_line("malformed", " ?RN");
        quiet("asleep");
        do_reset(1'b1);
        check_val("restored", 16'(aumc_pkg::MODE_POLL), 16'(mode));
    endtask
    initial begin
        t_stream();
        t_poll();
        t_comp();
        t_sleep();
        finish_test();
    end
    initial begin
        repeat (60000) @(posedge mclk);
        err_total++;
        finish_test();
    end
endmodule
bind aumc_ctrl aumc_ctrl_assertions #(
    .BIT_CYCLES(BIT_CYCLES), .REPORT_CYCLES(REPORT_CYCLES)) aumc_ctrl_assertions_i (
    .mclk(mclk), .reset(reset), .nv_poll_in(nv_poll_in), .tx_out(tx_out),
    .meas_start(meas_start), .mode(mode), .nv_wr(nv_wr), .nv_poll(nv_poll));
